// ---- hw/tpc_cfg.svh ----
// Purpose: Addresses, field positions, reset values and clock codes.
// Assumes: The system clock is the peripheral clock fxx.
// Notes: The clock-source codes are kept here so that they can be remapped.
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

`define TPC_ADDR_EDGE_CLK 32'hfffff216
`define TPC_ADDR_CLK_EXT 32'hfffff21e
`define TPC_RESET_BYTE 8'h00
`define TPC_EDGE_CLK_MASK 8'hf3
`define TPC_CLK_EXT_MASK 8'h01

`define TPC_EB_HI 7
`define TPC_EB_LO 6
`define TPC_EA_HI 5
`define TPC_EA_LO 4
`define TPC_CODE_B1 1
`define TPC_CODE_B0 0
`define TPC_CODE_B2 0

`define TPC_EDGE_FALL 2'h0
`define TPC_EDGE_RISE 2'h1
`define TPC_EDGE_BAD 2'h2
`define TPC_EDGE_BOTH 2'h3

`define TPC_CODE_DIV2 3'h0
`define TPC_CODE_DIV4 3'h1
`define TPC_CODE_DIV16 3'h2
`define TPC_CODE_DIV32 3'h3
`define TPC_CODE_DIV128 3'h4
`define TPC_CODE_DIV256 3'h5
`define TPC_CODE_EXT 3'h6
`define TPC_CODE_BAD 3'h7

`define TPC_MASK_DIV2 8'h01
`define TPC_MASK_DIV4 8'h03
`define TPC_MASK_DIV16 8'h0f
`define TPC_MASK_DIV32 8'h1f
`define TPC_MASK_DIV128 8'h7f
`define TPC_MASK_DIV256 8'hff

`endif

// ---- hw/tpc_edge_filter.sv ----
// Purpose: Two-sample noise filter and valid-edge detector for one input.
// Assumes: pin is synchronous to clk.
// Notes: Until first enabled after reset the settled level is held at 0.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tpc_edge_filter (
	input wire logic clk,
	input wire logic srst,
	input wire logic pin,
	input wire logic sample,
	input wire logic run,
	input wire logic [1:0] edge_sel,
	output logic evt
);
	import tpc_pkg::*;
	tpc_flt_s q;
	tpc_flt_s next_q;
	logic settle;
	logic hit;

	always_comb begin
		next_q = q;
		next_q.evt = 1'b0;
		settle = (q.s0 == q.s1) && (q.s1 != q.level);
		hit = 1'b0;
		unique case (edge_sel) // see [RQ3] [RQ4]
			`TPC_EDGE_FALL: hit = !q.s1;
			`TPC_EDGE_RISE: hit = q.s1;
			`TPC_EDGE_BAD: hit = 1'b0;
			`TPC_EDGE_BOTH: hit = 1'b1;
		endcase
		if (sample) begin
			next_q.s0 = pin;
			next_q.s1 = q.s0;
			// Stopped after the first run, the level tracks quietly so that
			// restarting does not report a stale edge.
			if (settle && (run || q.primed)) begin // see [RQ17] [RQ10]
				next_q.level = q.s1;
				next_q.evt = run && hit;
			end
		end
		if (run) begin
			next_q.primed = 1'b1;
		end
		if (srst) begin
			next_q = '0;
		end
	end

	always_ff @(posedge clk) begin
		q <= next_q;
	end

	assign evt = q.evt;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_two_samples: assert property ((q.level != $past(q.level)) // see [RQ17]
		|-> $past(q.s0) == q.level && $past(q.s1) == q.level)
		else $error("level changed without two equal samples");
	a_bad_edge: assert property (q.evt |-> $past(edge_sel) != `TPC_EDGE_BAD) // see [RQ3]
		else $error("edge reported for barred edge code");
	a_reset_low: assert property ($past(srst) |-> !q.level && !q.primed) // see [RQ10]
		else $error("filter level not low after reset");
endmodule

// ---- hw/tpc_pkg.sv ----
// Purpose: Types shared by the timer files.
// Assumes: Nothing beyond the configuration header.
// Notes: Each module keeps all its state in one struct from here.
package tpc_pkg;
	typedef enum logic [2:0] {
		TPC_STOP = 3'h0,
		TPC_INTERVAL = 3'h1,
		TPC_PPG = 3'h2,
		TPC_CAP_SINGLE = 3'h3,
		TPC_CAP_DUAL = 3'h4,
		TPC_CAP_RESTART = 3'h5
	} tpc_mode_e;

	typedef struct packed {
		logic [7:0] cnt;
	} tpc_pre_s;

	typedef struct packed {
		logic s0;
		logic s1;
		logic level;
		logic primed;
		logic evt;
	} tpc_flt_s;

	typedef struct packed {
		logic [7:0] edge_clk;
		logic [7:0] clk_ext;
		logic [15:0] count;
		logic [15:0] cap0;
		logic [15:0] cap1;
		logic irq0;
		logic irq1;
		logic tout;
		logic [7:0] rdata;
	} tpc_main_s;
endpackage

// ---- hw/tpc_prescale.sv ----
// Purpose: Divides fxx and picks the count-clock tick for a clock code.
// Assumes: clk is fxx.
// Notes: Ticks are one-cycle strobes; the external and barred codes give no tick, but tick_fast still runs.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module tpc_prescale (
	input wire logic clk,
	input wire logic srst,
	input wire logic [2:0] code,
	output logic tick,
	output logic tick_fast
);
	import tpc_pkg::*;
	tpc_pre_s q;
	tpc_pre_s next_q;
	logic [7:0] mask;
	logic use_div;

	always_comb begin
		mask = `TPC_MASK_DIV2;
		use_div = 1'b1;
		unique case (code)
			`TPC_CODE_DIV2: mask = `TPC_MASK_DIV2;
			`TPC_CODE_DIV4: mask = `TPC_MASK_DIV4;
			`TPC_CODE_DIV16: mask = `TPC_MASK_DIV16;
			`TPC_CODE_DIV32: mask = `TPC_MASK_DIV32;
			`TPC_CODE_DIV128: mask = `TPC_MASK_DIV128;
			`TPC_CODE_DIV256: mask = `TPC_MASK_DIV256;
			`TPC_CODE_EXT: use_div = 1'b0;
			`TPC_CODE_BAD: use_div = 1'b0;
		endcase
		next_q = q;
		next_q.cnt = q.cnt + 8'h01;
		if (srst) begin
			next_q.cnt = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		q <= next_q;
	end

	assign tick = use_div && ((q.cnt & mask) == mask); // see [RQ5] [RQ6]
	assign tick_fast = q.cnt[0];

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_div2_rate: assert property ((code == `TPC_CODE_DIV2) && tick // see [RQ5]
		|=> !tick || !$stable(code)) else $error("fxx/2 tick too fast");
	a_div4_rate: assert property (((code == `TPC_CODE_DIV4) && tick) // see [RQ5]
		##1 $stable(code)[*4] |-> !$past(tick) && tick)
		else $error("fxx/4 tick spacing wrong");
	a_div256_rate: assert property ((code == `TPC_CODE_DIV256) && tick // see [RQ6]
		|-> q.cnt == 8'hff) else $error("fxx/256 tick misplaced");
endmodule

// ---- hw/tpc_timer.sv ----
// Purpose: 16-bit timer with prescaler, interval, pulse and capture modes.
// Assumes: Byte bus writes and reads; mode and compares come on plain ports.
// Notes: Registers other than the two selects are plain ports, not mapped.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
// How it works
// [RQ1] Reset clears both clock-select registers to zero.
// [RQ2] Both select registers are written by byte accesses on the bus.
// [RQ3] Bits 7:6 pick the second input's edge: fall, rise, both; 10 barred.
// [RQ4] Bits 5:4 pick the first input's edge likewise; 10 barred.
// [RQ5] Three-bit clock code; 000 is fxx/2 and 001 is fxx/4.
// [RQ6] Other codes give fxx/16, /32, /128, /256, external edge, one barred.
// [RQ7] External clock pulses must last over two fxx/2 periods.
// [RQ8] Software must not reuse the counting edge as trigger or capture.
// [RQ9] Software stops the timer before writing a select register.
// [RQ10] High input after reset gives an edge at once; not after restart.
// [RQ11] Interval mode: match with compare zero clears count and flags irq.
// [RQ12] Pulse mode: compare zero sets period, compare one sets width.
// [RQ13] Single capture: first input edge loads capture one and flags irq.
// [RQ14] Single capture uses the bits 7:6 edge field for the first input.
// [RQ15] Dual capture: first input edge, bits 5:4, loads capture one.
// [RQ16] Dual capture: second input edge, bits 7:6, loads capture zero.
// [RQ17] Inputs sampled at count clock; two equal samples before capture.
// [RQ18] Width measured free-running or by restarting on first input edge.
// [RQ19] Clock codes are named constants; the barred code holds the count.
// [RQ20] Unused select bits read as zero and ignore writes.
module tpc_timer (
	input wire logic clk,
	input wire logic srst,
	input wire logic [31:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire tpc_pkg::tpc_mode_e timer_mode_ctrl,
	input wire logic [15:0] compare_zero,
	input wire logic [15:0] compare_one,
	input wire logic capture_pin_a_ch1,
	input wire logic capture_pin_b_ch1,
	output logic [15:0] counter_value,
	output logic [15:0] compare_capture_zero,
	output logic [15:0] compare_capture_one,
	output logic irq_match_zero,
	output logic irq_capture_one,
	output logic timer_output_pin
);
	import tpc_pkg::*;
	tpc_main_s q;
	tpc_main_s next_q;
	logic [2:0] clock_code;
	logic [1:0] edge_sel_a;
	logic [1:0] edge_sel_b;
	logic [1:0] sel_pin_a;
	logic pre_tick;
	logic fast_tick;
	logic sample_tick;
	logic count_tick;
	logic run;
	logic evt_a;
	logic evt_b;
	logic hit_edge;
	logic hit_ext;
	logic match0;

	assign clock_code = {q.clk_ext[`TPC_CODE_B2], // see [RQ5]
		q.edge_clk[`TPC_CODE_B1:`TPC_CODE_B0]};
	assign edge_sel_a = q.edge_clk[`TPC_EA_HI:`TPC_EA_LO]; // see [RQ4]
	assign edge_sel_b = q.edge_clk[`TPC_EB_HI:`TPC_EB_LO]; // see [RQ3]
	// Single capture takes its edge from the bits 7:6 field.
	assign sel_pin_a = (timer_mode_ctrl == TPC_CAP_SINGLE) ? // see [RQ14]
		edge_sel_b : edge_sel_a;
	assign run = (timer_mode_ctrl != TPC_STOP);
	// The external source is filtered at fxx/2, which is why its pulses
	// must outlast two of those periods.
	assign sample_tick = (clock_code == `TPC_CODE_EXT) ? // see [RQ7] [RQ17]
		fast_tick : pre_tick;

	tpc_prescale u_prescale (
		.clk(clk),
		.srst(srst),
		.code(clock_code),
		.tick(pre_tick),
		.tick_fast(fast_tick)
	);

	tpc_edge_filter u_filter_a (
		.clk(clk),
		.srst(srst),
		.pin(capture_pin_a_ch1),
		.sample(sample_tick),
		.run(run),
		.edge_sel(sel_pin_a),
		.evt(evt_a)
	);

	tpc_edge_filter u_filter_b (
		.clk(clk),
		.srst(srst),
		.pin(capture_pin_b_ch1),
		.sample(sample_tick),
		.run(run),
		.edge_sel(edge_sel_b),
		.evt(evt_b)
	);

	// With the external code the first input's edge is the count clock, so
	// hit_edge masks it off and it is never also used to capture.
	assign hit_ext = (clock_code == `TPC_CODE_EXT); // see [RQ8]
	assign hit_edge = evt_a && !hit_ext;
	// The barred code yields no tick, so the counter holds.
	assign count_tick = hit_ext ? evt_a : pre_tick; // see [RQ19]
	assign match0 = (q.count == compare_zero);

	always_comb begin
		next_q = q;
		next_q.irq0 = 1'b0;
		next_q.irq1 = 1'b0;
		next_q.rdata = 8'h00;
		// Writes while running are not guarded; software stops first.
		if (bus_wr && (bus_addr == `TPC_ADDR_EDGE_CLK)) begin // see [RQ2] [RQ9]
			next_q.edge_clk = bus_wdata & `TPC_EDGE_CLK_MASK; // see [RQ20]
		end
		if (bus_wr && (bus_addr == `TPC_ADDR_CLK_EXT)) begin // see [RQ2]
			next_q.clk_ext = bus_wdata & `TPC_CLK_EXT_MASK; // see [RQ20]
		end
		if (bus_rd && (bus_addr == `TPC_ADDR_EDGE_CLK)) begin
			next_q.rdata = q.edge_clk;
		end
		if (bus_rd && (bus_addr == `TPC_ADDR_CLK_EXT)) begin
			next_q.rdata = q.clk_ext;
		end
		unique case (timer_mode_ctrl)
			TPC_STOP: begin
				next_q.count = 16'h0000;
			end
			TPC_INTERVAL, TPC_PPG: begin
				if (count_tick) begin
					if (match0) begin // see [RQ11] [RQ12]
						next_q.count = 16'h0000;
						next_q.irq0 = 1'b1;
					end else begin
						next_q.count = q.count + 16'h0001;
					end
				end
			end
			TPC_CAP_SINGLE: begin
				if (count_tick) begin
					next_q.count = q.count + 16'h0001;
				end
				if (hit_edge) begin // see [RQ13] [RQ18]
					next_q.cap1 = q.count;
					next_q.irq1 = 1'b1;
				end
			end
			TPC_CAP_DUAL: begin
				if (count_tick) begin
					next_q.count = q.count + 16'h0001;
				end
				if (hit_edge) begin // see [RQ15]
					next_q.cap1 = q.count;
					next_q.irq1 = 1'b1;
				end
				if (evt_b) begin // see [RQ16]
					next_q.cap0 = q.count;
					next_q.irq0 = 1'b1;
				end
			end
			TPC_CAP_RESTART: begin
				if (count_tick) begin
					next_q.count = q.count + 16'h0001;
				end
				// The capture takes the old value before the restart.
				if (hit_edge) begin // see [RQ18]
					next_q.cap1 = q.count;
					next_q.irq1 = 1'b1;
					next_q.count = 16'h0000;
				end
			end
			default: begin
				next_q.count = 16'h0000;
			end
		endcase
		// High while the count is below the width, low for the rest.
		next_q.tout = (timer_mode_ctrl == TPC_PPG) && // see [RQ12]
			(next_q.count < compare_one);
		if (srst) begin
			next_q = '0; // see [RQ1]
			next_q.edge_clk = `TPC_RESET_BYTE;
			next_q.clk_ext = `TPC_RESET_BYTE;
		end
	end

	always_ff @(posedge clk) begin
		q <= next_q;
	end

	assign bus_rdata = q.rdata;
	assign counter_value = q.count;
	assign compare_capture_zero = q.cap0;
	assign compare_capture_one = q.cap1;
	assign irq_match_zero = q.irq0;
	assign irq_capture_one = q.irq1;
	assign timer_output_pin = q.tout;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_reset_clears: assert property ($past(srst) |-> // see [RQ1]
		q.edge_clk == 8'h00 && q.clk_ext == 8'h00 && !irq_match_zero)
		else $error("select registers not cleared by reset");
	a_byte_write: assert property (bus_wr && // see [RQ2]
		bus_addr == `TPC_ADDR_EDGE_CLK |=>
		q.edge_clk == ($past(bus_wdata) & 8'hf3))
		else $error("edge select write not stored");
	a_read_back: assert property (bus_rd && // see [RQ20]
		bus_addr == `TPC_ADDR_CLK_EXT |=> bus_rdata[7:1] == 7'h00 &&
		bus_rdata[0] == $past(q.clk_ext[0]))
		else $error("extension read shows unused bits");
	a_interval_wrap: assert property (timer_mode_ctrl == TPC_INTERVAL && // see [RQ11]
		count_tick && match0 |=> counter_value == 16'h0000 && irq_match_zero)
		else $error("interval match did not clear and flag");
	a_pulse_level: assert property ($past(timer_mode_ctrl) == TPC_PPG // see [RQ12]
		|-> timer_output_pin == (counter_value < $past(compare_one)))
		else $error("pulse output level wrong");
	a_single_cap: assert property (timer_mode_ctrl == TPC_CAP_SINGLE && // see [RQ13]
		hit_edge |=> compare_capture_one == $past(counter_value) &&
		irq_capture_one) else $error("single capture missed");
	a_dual_cap_one: assert property (timer_mode_ctrl == TPC_CAP_DUAL && // see [RQ15]
		hit_edge |=> compare_capture_one == $past(counter_value))
		else $error("dual capture one missed");
	a_dual_cap_zero: assert property (timer_mode_ctrl == TPC_CAP_DUAL && // see [RQ16]
		evt_b |=> compare_capture_zero == $past(counter_value) &&
		irq_match_zero) else $error("dual capture zero missed");
	a_restart_clear: assert property (timer_mode_ctrl == TPC_CAP_RESTART && // see [RQ18]
		hit_edge |=> counter_value == 16'h0000 && irq_capture_one)
		else $error("restart capture did not clear count");
	a_barred_hold: assert property (clock_code == `TPC_CODE_BAD && // see [RQ19]
		timer_mode_ctrl == TPC_INTERVAL |=> $stable(counter_value))
		else $error("counter moved on barred clock code");
	a_select_field: assert property (timer_mode_ctrl == TPC_CAP_SINGLE // see [RQ14]
		|-> sel_pin_a == q.edge_clk[7:6])
		else $error("single capture edge field wrong");

	c_interval_irq: cover property (timer_mode_ctrl == TPC_INTERVAL &&
		irq_match_zero);
	c_single_cap: cover property (timer_mode_ctrl == TPC_CAP_SINGLE &&
		irq_capture_one);
	c_pulse_rise: cover property ($rose(timer_output_pin));
	c_dual_zero: cover property (timer_mode_ctrl == TPC_CAP_DUAL &&
		irq_match_zero);
endmodule

// ---- tb/test_tpc_timer.sv ----
// Purpose: Self-checking bench for the prescaled capture timer.
// Assumes: Expected values come from the clock-code table and edge codes.
// Notes: Tick phase is free, so timing figures allow one to three ticks of slack.
`timescale 1ns/1ps
`include "tpc_cfg.svh"
module test_tpc_timer;
	import tpc_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [31:0] bus_addr = 32'h0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] bus_rdata;
	tpc_mode_e mode = TPC_STOP;
	logic [15:0] cz = 16'h0;
	logic [15:0] c1 = 16'h0;
	logic lvl_a = 1'b1;
	logic lvl_b = 1'b0;
	logic glitch_a = 1'b0;
	logic pin_a, pin_b, irq0, irq1, tout;
	logic [15:0] cnt, cap0, cap1, last_cap1;
	logic [7:0] rv;
	int miscompares = 0;
	int n_compared = 0;
	int n0, n1, nhi, r;
	int cycles = 0;
	int shift_tab[6] = '{1, 2, 4, 5, 7, 8};
	logic [1:0] edge_tab[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
	int exp_tab[4] = '{1, 1, 2, 0};

	tpc_pulse_src src_u (.clk(clk), .lvl_a(lvl_a), .lvl_b(lvl_b),
		.glitch_a(glitch_a), .pin_a(pin_a), .pin_b(pin_b));
	tpc_timer dut_u (.clk(clk), .srst(srst), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .timer_mode_ctrl(mode), .compare_zero(cz),
		.compare_one(c1), .capture_pin_a_ch1(pin_a),
		.capture_pin_b_ch1(pin_b), .counter_value(cnt),
		.compare_capture_zero(cap0), .compare_capture_one(cap1),
		.irq_match_zero(irq0), .irq_capture_one(irq1),
		.timer_output_pin(tout));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// A hung wait is cut short well past the few thousand cycles needed.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic near(string what, logic [15:0] seen, int exp, int tol);
		chk(what, {31'h0, (seen >= exp - tol) && (seen <= exp + tol)}, 1);
	endtask

	task automatic wr(logic [31:0] a, logic [7:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rd(logic [31:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask

	task automatic go(tpc_mode_e m);
		@(posedge clk);
		mode <= m;
	endtask

	task automatic setup(logic [3:0] edges, logic [2:0] code);
		go(TPC_STOP);
		wr(`TPC_ADDR_EDGE_CLK, {edges, 2'b00, code[1:0]});
		wr(`TPC_ADDR_CLK_EXT, {7'h00, code[2]});
		n0 = 0;
		n1 = 0;
		nhi = 0;
	endtask

	// Counts events each cycle and checks captured values against the count.
	task automatic watch(int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			if (tout === 1'b1) nhi++;
			if (irq0 === 1'b1) begin
				n0++;
				if (mode == TPC_CAP_DUAL) near("cap0", cnt - cap0, 1, 1);
			end
			if (irq1 === 1'b1) begin
				n1++;
				last_cap1 = cap1;
				if (mode != TPC_CAP_RESTART) near("cap1", cnt - cap1, 1, 1);
			end
			if (mode == TPC_INTERVAL && cnt > cz) chk("bound", cnt, cz);
		end
	endtask

	task automatic pins(logic a, logic b, int hold);
		@(posedge clk);
		lvl_a <= a;
		lvl_b <= b;
		watch(hold);
	endtask

	initial begin
		r = $urandom(32'h291f);
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(`TPC_ADDR_EDGE_CLK, rv);
		chk("sel reset", rv, 8'h00);
		rd(`TPC_ADDR_CLK_EXT, rv);
		chk("ext reset", rv, 8'h00);
		wr(`TPC_ADDR_EDGE_CLK, 8'hff);
		rd(`TPC_ADDR_EDGE_CLK, rv);
		chk("sel rw", rv, 8'hf3);
		wr(`TPC_ADDR_CLK_EXT, 8'hff);
		rd(`TPC_ADDR_CLK_EXT, rv);
		chk("ext rw", rv, 8'h01);
		rd(32'hfffff21a, rv);
		chk("unmapped", rv, 8'h00);
		// Pin was high through reset, so the first run sees a rise at once.
		setup(4'b0100, 3'h0);
		go(TPC_CAP_SINGLE);
		watch(30);
		near("first rise", 16'(n1), 1, 0);
		setup(4'b0100, 3'h0);
		go(TPC_CAP_SINGLE);
		watch(30);
		near("rerun", 16'(n1), 0, 0);
		go(TPC_STOP);
		pins(1'b0, 1'b0, 20);
		// Every edge code on the upper field, one pulse each.
		for (int i = 0; i < 4; i++) begin
			setup({edge_tab[i], 2'b00}, 3'h0);
			go(TPC_CAP_SINGLE);
			pins(1'b1, 1'b0, 30);
			pins(1'b0, 1'b0, 30);
			near("single edges", 16'(n1), exp_tab[i], 0);
		end
		setup(4'b1100, 3'h0);
		go(TPC_CAP_SINGLE);
		@(posedge clk);
		glitch_a <= 1'b1;
		@(posedge clk);
		glitch_a <= 1'b0;
		watch(30);
		near("glitch", 16'(n1), 0, 0);
		// Dual: first input rises, second input falls.
		setup(4'b0001, 3'h0);
		go(TPC_CAP_DUAL);
		pins(1'b1, 1'b0, 30);
		pins(1'b0, 1'b0, 30);
		near("dual a", 16'(n1 * 2 + n0), 2, 0);
		pins(1'b0, 1'b1, 30);
		pins(1'b0, 1'b0, 30);
		near("dual b", 16'(n0 * 2 + n1), 3, 0);
		// Restart: the second rise captures the ticks since the first.
		setup(4'b0001, 3'h0);
		go(TPC_CAP_RESTART);
		pins(1'b1, 1'b0, 40);
		pins(1'b0, 1'b0, 160);
		pins(1'b1, 1'b0, 40);
		near("restart", last_cap1, 100, 3);
		pins(1'b0, 1'b0, 20);
		// Each divided clock code, counting for 1024 cycles.
		@(posedge clk);
		cz <= 16'hffff;
		for (int i = 0; i < 6; i++) begin
			setup(4'b0000, 3'(i));
			go(TPC_INTERVAL);
			watch(1024);
			near("divider", cnt, 1024 >> shift_tab[i], 1);
		end
		setup(4'b0000, 3'h7);
		go(TPC_INTERVAL);
		watch(600);
		near("barred code", cnt, 0, 0);
		// External clock from the first input; it is not a capture source.
		setup(4'b0001, 3'h6);
		go(TPC_INTERVAL);
		repeat (3) begin
			pins(1'b1, 1'b0, 12);
			pins(1'b0, 1'b0, 12);
		end
		near("external", cnt, 3, 0);
		// Interval with a random compare value.
		setup(4'b0000, 3'h0);
		@(posedge clk);
		cz <= 16'(3 + $urandom % 8);
		go(TPC_INTERVAL);
		watch(20 * (int'(cz) + 1));
		near("interval", 16'(n0), 10, 1);
		// Pulse mode: period ten ticks, width three ticks.
		setup(4'b0000, 3'h0);
		@(posedge clk);
		cz <= 16'h0009;
		c1 <= 16'h0003;
		go(TPC_PPG);
		watch(400);
		near("ppg width", 16'(nhi), 120, 4);
		near("ppg period", 16'(n0), 20, 1);
		results();
	end
endmodule

// ---- tb/tpc_pulse_src.sv ----
// Purpose: Pulse source standing on the two capture input pins.
// Assumes: Levels are requested by the bench; glitch_a is a one-cycle strobe.
// Notes: Level changes are held back until the old level has lasted long
// enough, so only the glitch input can make a pulse shorter than allowed.
`timescale 1ns/1ps
module tpc_pulse_src (
	input wire logic clk,
	input wire logic lvl_a,
	input wire logic lvl_b,
	input wire logic glitch_a,
	output logic pin_a,
	output logic pin_b
);
	logic pin_a_r = 1'b1;
	logic pin_b_r = 1'b0;
	logic [3:0] age_a = 4'h0;
	logic [3:0] age_b = 4'h0;

	// A level lasts five cycles at least, past two fxx/2 periods.
	always_ff @(posedge clk) begin
		if (lvl_a != pin_a_r && age_a >= 4'h5) begin
			pin_a_r <= lvl_a;
			age_a <= 4'h0;
		end else if (age_a != 4'hf) begin
			age_a <= age_a + 4'h1;
		end
		if (lvl_b != pin_b_r && age_b >= 4'h5) begin
			pin_b_r <= lvl_b;
			age_b <= 4'h0;
		end else if (age_b != 4'hf) begin
			age_b <= age_b + 4'h1;
		end
	end

	// The glitch is the only short pulse, and only when the bench asks.
	assign pin_a = pin_a_r ^ glitch_a;
	assign pin_b = pin_b_r;
endmodule
